// [rtl/aswc_pkg.sv]
// constants, event carrier and mode states for the auto sleep/wake controller
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package aswc_pkg;

    // timing: ms times kHz gives cycles
    localparam int unsigned ASWC_CLK_KHZ = 200000;
    localparam int unsigned ASWC_STEP_MS = 320;
    localparam int unsigned ASWC_STEP_CYC = ASWC_STEP_MS * ASWC_CLK_KHZ;
    localparam int ASWC_BASE_W = 27;

    // register indices; byte address is four times the index
    localparam logic [7:0] ASWC_IDX_SYSMODE = 8'h0b;
    localparam logic [7:0] ASWC_IDX_SLEEP_CNT = 8'h29;
    localparam logic [7:0] ASWC_IDX_MTHS_CFG = 8'h52;
    localparam logic [7:0] ASWC_IDX_MVECM_CFG = 8'h69;
    localparam logic [7:0] ASWC_IDX_MAIN = 8'h30;
    localparam logic [7:0] ASWC_IDX_SECOND = 8'h31;
    localparam logic [7:0] ASWC_IDX_WAKE = 8'h32;
    localparam logic [7:0] ASWC_IDX_INT_EN = 8'h33;
    localparam logic [7:0] ASWC_IDX_ROUTE = 8'h34;
    localparam logic [7:0] ASWC_IDX_INT_SRC = 8'h35;

    // field positions
    localparam int ASWC_MAIN_ACTIVE_BIT = 0;
    localparam int ASWC_MAIN_ARATE_LSB = 3;
    localparam int ASWC_MAIN_SRATE_LSB = 6;
    localparam int ASWC_SECOND_HYB_BIT = 0;
    localparam int ASWC_SECOND_SLPE_BIT = 2;
    localparam int ASWC_WAKE_GATE_BIT = 11;
    localparam int ASWC_CFG_ROUTE_BIT = 0;
    localparam int ASWC_SYSTEM_MODE_REG_FGERR_BIT = 7;
    localparam int ASWC_EVT_ASLP_BIT = 5;
    localparam int ASWC_EVT_DRDY_BIT = 7;

    // reset values
    localparam logic [7:0] ASWC_RST_MAIN = 8'h00;
    localparam logic [7:0] ASWC_RST_SECOND = 8'h00;
    localparam logic [7:0] ASWC_RST_SLEEP_CNT = 8'h00;
    localparam logic [11:0] ASWC_RST_WAKE = 12'h000;
    localparam logic [10:0] ASWC_RST_INT_EN = 11'h000;
    localparam logic [10:0] ASWC_RST_ROUTE = 11'h000;

    // event classes: restart excludes data-ready and sleep-change, wake also fifo
    localparam logic [10:0] ASWC_RESTART_MASK = 11'h75f;
    localparam logic [10:0] ASWC_WAKE_MASK = 11'h75e;
    localparam logic [10:0] ASWC_ROUTE_REG_MASK = 11'h1ff;

    // rate codes and system mode codes
    localparam logic [2:0] ASWC_RATE_SLOWEST = 3'h7;
    localparam logic [1:0] ASWC_SYS_STANDBY = 2'h0;
    localparam logic [1:0] ASWC_SYS_WAKE = 2'h1;
    localparam logic [1:0] ASWC_SYS_SLEEP = 2'h2;

    // event flags from the detectors, bit 0 is the fifo source
    typedef struct packed {
        logic mag_threshold_source;
        logic mag_magnitude_source;
        logic accel_magnitude_source;
        logic data_ready_source;
        logic magnetic_event_source;
        logic sleep_change_source;
        logic freefall_motion_source;
        logic tap_event_source;
        logic orientation_event_source;
        logic transient_event_source;
        logic fifo_event_source;
    } aswc_evt_t;

    typedef enum logic [2:0] {
        ASWC_STANDBY = 3'b001,
        ASWC_WAKE = 3'b010,
        ASWC_SLEEP = 3'b100
    } aswc_mode_t;

endpackage

// [rtl/aswc_step_timer.sv]
// step period generator for the inactivity counter
`timescale 1ns/10ps
`default_nettype none
module aswc_step_timer import aswc_pkg::*; #(
    parameter int unsigned STEP_CYCLES = ASWC_STEP_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [1:0] mult,
    output logic step
);

    logic [ASWC_BASE_W-1:0] base;
    logic [1:0] sub;
    logic base_end;
    logic [1:0] sub_last;

    // mult 0/1/2 stretches the step to 1x, 2x or 4x the base period
    assign base_end = (base == ASWC_BASE_W'(STEP_CYCLES - 1));
    assign sub_last = (mult == 2'h0) ? 2'h0 : ((mult == 2'h1) ? 2'h1 : 2'h3);

    // base prescaler and step divider, both cleared by a restart
    always_ff @(posedge ref_clk) begin
        if (!rst_n || restart) begin
            base <= '0;
            sub <= 2'h0;
            step <= 1'b0;
        end else begin
            step <= 1'b0;
            if (base_end) begin
                base <= '0;
                if (sub >= sub_last) begin
                    sub <= 2'h0;
                    step <= 1'b1;
                end else begin
                    sub <= sub + 2'h1;
                end
            end else begin
                base <= base + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// [rtl/aswc_top.sv]
// auto sleep/wake sequencer with interrupt pin routing and avalon register slave
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module aswc_top import aswc_pkg::*; #(
    parameter int unsigned STEP_CYCLES = ASWC_STEP_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire aswc_evt_t evt_in,
    input wire logic fifo_empty,
    output logic irq_pin_a,
    output logic irq_pin_b,
    output logic [2:0] sample_rate_sel,
    output logic sleep_mode,
    output aswc_evt_t func_enable,
    output logic fifo_accept_en,
    output logic fifo_flush
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [7:0] main_control_reg;
    logic [7:0] second_control_reg;
    logic [11:0] wake_control_reg;
    logic [10:0] int_enable_reg;
    logic [10:0] irq_route_reg;
    logic [7:0] sleep_inactivity_count;
    logic mths_route_cfg;
    logic mvecm_route_cfg;
    logic sleep_change_flag;
    logic fifo_gate_err;
    aswc_mode_t mode;
    logic [7:0] idle_cnt;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
        hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    logic wr_go;
    logic rd_go;
    assign wr_go = avs_write && !avs_waitrequest;
    assign rd_go = avs_read && !avs_waitrequest;

    // ------------------------------------------------------------------
    // event qualification
    // ------------------------------------------------------------------
    logic [10:0] live;
    logic [10:0] eff_en;
    logic [10:0] hot;
    logic [10:0] route;
    logic restart_hit;
    logic wake_hit;
    logic slpe;
    logic hybrid;
    logic gate;
    logic [2:0] arate;
    logic [1:0] mult;
    logic step;
    logic enter_sleep;
    logic leave_sleep;
    logic sys_active;

    assign slpe = second_control_reg[ASWC_SECOND_SLPE_BIT];
    assign hybrid = second_control_reg[ASWC_SECOND_HYB_BIT];
    assign gate = wake_control_reg[ASWC_WAKE_GATE_BIT];
    assign arate = main_control_reg[ASWC_MAIN_ARATE_LSB +: 3];
    assign sys_active = main_control_reg[ASWC_MAIN_ACTIVE_BIT];

    // the detectors' own sleep-change input is replaced by the sticky flag
    always_comb begin
        live = evt_in;
        live[ASWC_EVT_ASLP_BIT] = sleep_change_flag;
    end

    // masked in sleep
    // while asleep only wake-capable events and the sleep-change flag stay enabled
    always_comb begin
        eff_en = int_enable_reg;
        if (mode == ASWC_SLEEP) begin
            eff_en = int_enable_reg & (wake_control_reg[10:0] | (11'h001 << ASWC_EVT_ASLP_BIT));
        end
    end

    assign hot = live & eff_en;
    assign restart_hit = |(hot & ASWC_RESTART_MASK);
    assign wake_hit = |(hot & ASWC_WAKE_MASK & wake_control_reg[10:0]);

    assign route = {mths_route_cfg, mvecm_route_cfg, irq_route_reg[8:0]};

    // slowest rate doubles, hybrid doubles again
    assign mult = {1'b0, arate == ASWC_RATE_SLOWEST} + {1'b0, hybrid};

    assign enter_sleep = (mode == ASWC_WAKE) && slpe && !restart_hit
        && (idle_cnt == sleep_inactivity_count);
    assign leave_sleep = (mode == ASWC_SLEEP) && wake_hit;

    // ------------------------------------------------------------------
    // step period
    // ------------------------------------------------------------------
    aswc_step_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_step (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .restart(restart_hit || mode != ASWC_WAKE),
        .mult(mult),
        .step(step)
    );

    // ------------------------------------------------------------------
    // avalon slave
    // ------------------------------------------------------------------
    // one wait state: the answer is ready the edge after the request appears
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    // read data is built while waitrequest is high, unmapped reads give zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= 32'h0000_0000;
            if (hit(avs_address, ASWC_IDX_MAIN))
                avs_readdata[7:0] <= main_control_reg;
            if (hit(avs_address, ASWC_IDX_SECOND))
                avs_readdata[7:0] <= second_control_reg;
            if (hit(avs_address, ASWC_IDX_WAKE))
                avs_readdata[11:0] <= wake_control_reg;
            if (hit(avs_address, ASWC_IDX_INT_EN))
                avs_readdata[10:0] <= int_enable_reg;
            if (hit(avs_address, ASWC_IDX_ROUTE))
                avs_readdata[10:0] <= irq_route_reg;
            if (hit(avs_address, ASWC_IDX_SLEEP_CNT))
                avs_readdata[7:0] <= sleep_inactivity_count;
            if (hit(avs_address, ASWC_IDX_MTHS_CFG))
                avs_readdata[ASWC_CFG_ROUTE_BIT] <= mths_route_cfg;
            if (hit(avs_address, ASWC_IDX_MVECM_CFG))
                avs_readdata[ASWC_CFG_ROUTE_BIT] <= mvecm_route_cfg;
            if (hit(avs_address, ASWC_IDX_INT_SRC))
                avs_readdata[10:0] <= hot;
            if (hit(avs_address, ASWC_IDX_SYSMODE)) begin
                avs_readdata[1:0] <= (mode == ASWC_SLEEP) ? ASWC_SYS_SLEEP :
                    ((mode == ASWC_WAKE) ? ASWC_SYS_WAKE : ASWC_SYS_STANDBY);
                avs_readdata[ASWC_SYSTEM_MODE_REG_FGERR_BIT] <= fifo_gate_err;
            end
        end
    end

    // configuration writes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            main_control_reg <= ASWC_RST_MAIN;
            second_control_reg <= ASWC_RST_SECOND;
            wake_control_reg <= ASWC_RST_WAKE;
            irq_route_reg <= ASWC_RST_ROUTE;
            sleep_inactivity_count <= ASWC_RST_SLEEP_CNT;
            mths_route_cfg <= 1'b0;
            mvecm_route_cfg <= 1'b0;
        end else if (wr_go) begin
            if (hit(avs_address, ASWC_IDX_MAIN))
                main_control_reg <= avs_writedata[7:0];
            if (hit(avs_address, ASWC_IDX_SECOND))
                second_control_reg <= avs_writedata[7:0];
            if (hit(avs_address, ASWC_IDX_WAKE))
                wake_control_reg <= {avs_writedata[11], avs_writedata[10:0] & ASWC_WAKE_MASK};
            if (hit(avs_address, ASWC_IDX_ROUTE))
                irq_route_reg <= avs_writedata[10:0] & ASWC_ROUTE_REG_MASK;
            if (hit(avs_address, ASWC_IDX_SLEEP_CNT))
                sleep_inactivity_count <= avs_writedata[7:0];
            if (hit(avs_address, ASWC_IDX_MTHS_CFG))
                mths_route_cfg <= avs_writedata[ASWC_CFG_ROUTE_BIT];
            if (hit(avs_address, ASWC_IDX_MVECM_CFG))
                mvecm_route_cfg <= avs_writedata[ASWC_CFG_ROUTE_BIT];
        end
    end

    // data-ready not restored
    // data-ready enable is dropped on sleep entry; a host write in that cycle loses
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_enable_reg <= ASWC_RST_INT_EN;
        end else if (enter_sleep) begin
            int_enable_reg[ASWC_EVT_DRDY_BIT] <= 1'b0;
        end else if (wr_go && hit(avs_address, ASWC_IDX_INT_EN)) begin
            int_enable_reg <= avs_writedata[10:0];
        end
    end

    // ------------------------------------------------------------------
    // sleep sequencer
    // ------------------------------------------------------------------
    // enter sleep, wake
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode <= ASWC_STANDBY;
        end else begin
            unique case (mode)
                ASWC_STANDBY: begin
                    if (sys_active)
                        mode <= ASWC_WAKE;
                end
                ASWC_WAKE: begin
                    if (!sys_active)
                        mode <= ASWC_STANDBY;
                    else if (enter_sleep)
                        mode <= ASWC_SLEEP;
                end
                ASWC_SLEEP: begin
                    if (!sys_active)
                        mode <= ASWC_STANDBY;
                    else if (leave_sleep)
                        mode <= ASWC_WAKE;
                end
                default: mode <= ASWC_STANDBY;
            endcase
        end
    end

    // one count per step; saturates at 8'hff, so a count lowered below idle_cnt never matches
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            idle_cnt <= 8'h00;
        end else if (mode != ASWC_WAKE || restart_hit || !slpe) begin
            idle_cnt <= 8'h00;
        end else if (step && idle_cnt != 8'hff) begin
            idle_cnt <= idle_cnt + 8'h01;
        end
    end

    // sticky sleep-change flag
    // a mode change wins over a system mode read in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sleep_change_flag <= 1'b0;
        end else if ((enter_sleep || leave_sleep) && int_enable_reg[ASWC_EVT_ASLP_BIT]) begin
            sleep_change_flag <= 1'b1;
        end else if (rd_go && hit(avs_address, ASWC_IDX_SYSMODE)) begin
            sleep_change_flag <= 1'b0;
        end
    end

    // gate only holds the fifo; mode changes proceed regardless
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fifo_gate_err <= 1'b0;
        end else if (enter_sleep && gate) begin
            fifo_gate_err <= 1'b1;
        end else if (fifo_empty) begin
            fifo_gate_err <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    // route bit selects pin, pins are OR of routed sources
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_pin_a <= 1'b0;
            irq_pin_b <= 1'b0;
        end else begin
            irq_pin_a <= |(hot & route);
            irq_pin_b <= |(hot & ~route);
        end
    end

    // sleep rate while asleep; sleep rates are the four slowest codes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sample_rate_sel <= 3'h0;
            sleep_mode <= 1'b0;
            func_enable <= '0;
            fifo_accept_en <= 1'b1;
            fifo_flush <= 1'b0;
        end else begin
            sample_rate_sel <= (mode == ASWC_SLEEP)
                ? {1'b1, main_control_reg[ASWC_MAIN_SRATE_LSB +: 2]} : arate;
            sleep_mode <= (mode == ASWC_SLEEP);
            func_enable <= eff_en;
            // held samples are kept instead of flushed when the gate is set
            fifo_accept_en <= !((enter_sleep && gate) || (fifo_gate_err && !fifo_empty));
            fifo_flush <= (enter_sleep || leave_sleep) && !gate;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_pin_a_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (evt_in.transient_event_source && int_enable_reg[1] && irq_route_reg[1]
        && mode != ASWC_SLEEP)
        |=> irq_pin_a)
        else $error("routed event missing on pin a");

    a_pin_b_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|(hot & ~route)) |=> irq_pin_b && (irq_pin_a == $past(|(hot & route))))
        else $error("pin b not the OR of its sources");

    a_mths_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hot[10] && mths_route_cfg) |=> irq_pin_a)
        else $error("magnetic threshold routing wrong");

    a_restart_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == ASWC_WAKE && sys_active && restart_hit)
        |=> idle_cnt == 8'h00 && mode == ASWC_WAKE)
        else $error("restart did not clear the idle count");

    a_sleep_enter: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == ASWC_WAKE && sys_active && slpe && !restart_hit
        && idle_cnt == sleep_inactivity_count) |=> ##1 sleep_mode)
        else $error("sleep not entered at count");

    a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == ASWC_WAKE && sys_active && slpe && step && !restart_hit
        && idle_cnt != sleep_inactivity_count && idle_cnt != 8'hff)
        |=> idle_cnt == $past(idle_cnt) + 8'h01)
        else $error("idle count did not advance");

    a_wake_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == ASWC_SLEEP && sys_active && wake_hit) |=> ##1 !sleep_mode)
        else $error("wake event ignored");

    a_change_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((enter_sleep || leave_sleep) && int_enable_reg[ASWC_EVT_ASLP_BIT])
        |=> sleep_change_flag)
        else $error("mode change raised no interrupt");

    a_gate_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enter_sleep && gate && !fifo_empty) |=> fifo_gate_err && !fifo_accept_en)
        else $error("fifo gate did not hold the fifo");

    a_drdy_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enter_sleep |=> !int_enable_reg[ASWC_EVT_DRDY_BIT])
        else $error("data-ready enable kept over sleep");

endmodule
`default_nettype wire

// [test/aswc_host_model.sv]
// host model: avalon master and interrupt service
`timescale 1ns/10ps
`default_nettype none
module aswc_host_model import aswc_pkg::*; (
    input wire logic ref_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [9:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata
);
    // bus idle from time zero
    initial begin
        avs_address = 10'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // one access, held until waitrequest is sampled low
    task automatic access(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rd);
        avs_address <= {idx, 2'b00};
        avs_writedata <= wd;
        avs_read <= ~wr;
        avs_write <= wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // idle edge so the next request never lands in this time step
        @(posedge ref_clk);
    endtask
    task automatic isr(output logic [31:0] src);
        access(1'b0, ASWC_IDX_INT_SRC, 32'h0, src);
    endtask
endmodule
`default_nettype wire

// [test/aswc_tb_top.sv]
// self-checking bench for the auto sleep/wake controller
`timescale 1ns/10ps
`default_nettype none
module aswc_tb_top import aswc_pkg::*;;
    logic ref_clk, rst_n, fifo_empty, wt, rq, wq, pa, pb, slp, fae, ffl;
    logic [9:0] ad;
    logic [31:0] wd, rdd;
    logic [2:0] rate;
    aswc_evt_t evt_in, fen;
    int n_errors = 0;
    int samples_checked = 0;
    int flushes = 0;
    aswc_top #(.STEP_CYCLES(8)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(ad),
        .avs_read(rq), .avs_write(wq), .avs_writedata(wd), .avs_readdata(rdd),
        .avs_waitrequest(wt), .evt_in(evt_in), .fifo_empty(fifo_empty), .irq_pin_a(pa),
        .irq_pin_b(pb), .sample_rate_sel(rate), .sleep_mode(slp), .func_enable(fen),
        .fifo_accept_en(fae), .fifo_flush(ffl));
    aswc_host_model host (.ref_clk(ref_clk), .avs_waitrequest(wt), .avs_readdata(rdd),
        .avs_address(ad), .avs_read(rq), .avs_write(wq), .avs_writedata(wd));
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;
    // flush is a one-cycle pulse, so count it on every edge instead of polling
    always @(posedge ref_clk) begin
        if (ffl === 1'b1) flushes++;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        host.access(1'b1, idx, d, x);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] x;
        host.access(1'b0, idx, 32'h0, x);
        chk(what, exp, x);
    endtask
    // events are levels; hold a few edges so the registered pins settle
    task automatic drive(input logic [10:0] e, input logic [1:0] ab);
        @(posedge ref_clk);
        evt_in <= e;
        repeat (3) @(posedge ref_clk);
        chk("pins a b", {30'h0, ab}, {30'h0, pa, pb});
    endtask
    task automatic pulse();
        @(posedge ref_clk);
        evt_in <= 11'h002;
        @(posedge ref_clk);
        evt_in <= 11'h000;
    endtask
    task automatic wait_slp(input logic lvl, output int n);
        n = 0;
        while (slp !== lvl && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    task automatic to_sleep(output int n);
        pulse();
        wait_slp(1'b0, n);
        wait_slp(1'b1, n);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_route();
        logic [31:0] s;
        rd(ASWC_IDX_SLEEP_CNT, 32'h0, "count reset");
        wr(ASWC_IDX_SLEEP_CNT, 32'ha5);
        rd(ASWC_IDX_SLEEP_CNT, 32'ha5, "count");
        rd(8'h01, 32'h0, "unmapped");
        wr(ASWC_IDX_INT_EN, 32'h403);
        wr(ASWC_IDX_ROUTE, 32'h002);
        wr(ASWC_IDX_MTHS_CFG, 32'h1);
        drive(11'h001, 2'b01);
        drive(11'h002, 2'b10);
        drive(11'h400, 2'b10);
        drive(11'h403, 2'b11);
        host.isr(s);
        chk("source", 32'h403, s);
        drive(11'h004, 2'b00);
        $display("test route done");
    endtask
    task automatic t_timing();
        logic [7:0] mains [3] = '{8'h01, 8'h39, 8'h39};
        logic [7:0] secs [3] = '{8'h04, 8'h04, 8'h05};
        int m [3] = '{1, 2, 4};
        int n;
        wr(ASWC_IDX_WAKE, 32'h002);
        wr(ASWC_IDX_INT_EN, 32'h0a3);
        wr(ASWC_IDX_SLEEP_CNT, 32'h2);
        for (int i = 0; i < 3; i++) begin
            wr(ASWC_IDX_MAIN, {24'h0, mains[i]});
            wr(ASWC_IDX_SECOND, {24'h0, secs[i]});
            to_sleep(n);
            chk("delay", 32'h1, {31'h0, n >= 16 * m[i] - 4 && n <= 16 * m[i] + 6});
            chk("sleep rate", 32'h4, {29'h0, rate});
            chk("pin b set", 32'h1, {31'h0, pb});
            chk("sleep enables", 32'h022, {21'h0, fen});
            rd(ASWC_IDX_SYSMODE, 32'h2, "mode");
            repeat (3) @(posedge ref_clk);
            chk("pin b clear", 32'h0, {31'h0, pb});
        end
        rd(ASWC_IDX_INT_EN, 32'h023, "enables");
        drive(11'h040, 2'b00);
        chk("still asleep", 32'h1, {31'h0, slp});
        chk("flushes", 32'h5, flushes);
        $display("test timing done");
    endtask
    task automatic t_restart_gate();
        int n;
        wr(ASWC_IDX_MAIN, 32'h01);
        wr(ASWC_IDX_SECOND, 32'h04);
        pulse();
        wait_slp(1'b0, n);
        chk("awake", 32'h0, {31'h0, slp});
        chk("awake enables", 32'h023, {21'h0, fen});
        repeat (8) begin
            repeat (10) @(posedge ref_clk);
            pulse();
        end
        chk("no sleep", 32'h0, {31'h0, slp});
        fifo_empty <= 1'b0;
        wr(ASWC_IDX_WAKE, 32'h802);
        to_sleep(n);
        chk("gated sleep", 32'h1, {31'h0, slp});
        chk("fifo held", 32'h0, {31'h0, fae});
        rd(ASWC_IDX_SYSMODE, 32'h82, "gate error");
        fifo_empty <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("fifo free", 32'h1, {31'h0, fae});
        chk("gated flushes", 32'h6, flushes);
        $display("test restart gate done");
    endtask
    initial begin
        rst_n = 1'b0;
        fifo_empty = 1'b1;
        evt_in = 11'h000;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_route();
        t_timing();
        t_restart_gate();
        complete_run();
    end
    // whole run is a few hundred cycles; 30000 cycles means a hang
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
